/* File: design/uvep_host.sv */
// Host controller that reads and programs the UV EPROM through its pins
`timescale 1ns/10ps
`default_nettype none
module uvep_host
  import uvep_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // User request
  input wire logic req_valid,
  input wire logic req_prog,
  input wire uvep_word_t req_word,
  output logic req_ready,
  // User answer
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic rsp_error,
  // EPROM pins
  output logic [ADDR_W-1:0] word_select_lines,
  output logic select_program_strobe_n,
  output logic output_gate_n,
  output logic supply_high,
  output logic [DATA_W-1:0] byte_lines_out,
  output logic byte_lines_oe,
  input wire logic [DATA_W-1:0] byte_lines_in
);

  // ----------------------------------------
  // Pin input synchroniser
  // ----------------------------------------
  // Bits may land a cycle apart; the byte is only read at the end of
  // a long settle window, so a split byte is never used
  logic [DATA_W-1:0] bl_s1_r, bl_s2_r;
  always_ff @(posedge clk) begin
    bl_s1_r <= byte_lines_in;
    bl_s2_r <= bl_s1_r;
  end

  // ----------------------------------------
  // State and counters
  // ----------------------------------------
  uvep_state_t st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  uvep_word_t word_r;
  uvep_ctl_t ctl_r, ctl_nxt;
  logic oe_r, oe_nxt;
  logic rsp_v_r, rsp_v_nxt, err_r, err_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic ready_r, ready_nxt;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction

  function automatic logic is_idle(input uvep_state_t s);
    is_idle = (s == ST_IDLE);
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire cnt_done = (cnt_r == '0);
  // Ready also holds off the first idle cycle after reset
  wire take = is_idle(st_r) && req_valid && ready_r;
  wire take_read = take && !req_prog;
  wire take_prog = take && req_prog;
  // Both sample points sit at the end of a gate-low window
  wire in_sample = (st_r == ST_RD_GATE) || (st_r == ST_PG_VERIFY);
  // Settle time on the sync path is two cycles beyond the pin timing
  wire sample = cnt_done && in_sample;
  // Ones may be cleared to zeros but a one cannot come back from a zero
  wire mismatch = (bl_s2_r != word_r.data);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_done ? cnt_r : cnt_r - 1'b1;
    ctl_nxt = ctl_r;
    oe_nxt = oe_r;
    rsp_v_nxt = 1'b0;
    err_nxt = err_r;
    case (st_r)
      ST_IDLE: begin
        if (take_read) begin
          // Select is the per-device choice, gate stays high until later
          ctl_nxt = '{select_n: 1'b0, gate_n: 1'b1, supply_hi: 1'b0};
          cnt_nxt = cyc(ACCESS_CYC + SYNC_CYC);
          st_nxt = ST_RD_ADDR;
        end else if (take_prog) begin
          // Byte and address together, select still high
          oe_nxt = 1'b1;
          ctl_nxt = CTL_IDLE;
          cnt_nxt = cyc(SETUP_CYC);
          st_nxt = ST_PG_SETUP;
        end
      end
      ST_RD_ADDR: if (cnt_done) begin
        // The gate alone now times the transfer
        ctl_nxt.gate_n = 1'b0;
        cnt_nxt = cyc(GATE_CYC + SYNC_CYC);
        st_nxt = ST_RD_GATE;
      end
      ST_RD_GATE: if (cnt_done) begin
        ctl_nxt = CTL_IDLE;
        rsp_v_nxt = 1'b1;
        err_nxt = 1'b0;
        cnt_nxt = cyc(FLOAT_CYC);
        st_nxt = ST_RD_FLOAT;
      end
      ST_PG_SETUP: if (cnt_done) begin
        // Supply pulse, then wait out its slow rising edge
        ctl_nxt.supply_hi = 1'b1;
        cnt_nxt = cyc(RISE_CYC + SETUP_CYC);
        st_nxt = ST_PG_RISE;
      end
      ST_PG_RISE: if (cnt_done) begin
        ctl_nxt.select_n = 1'b0;
        cnt_nxt = CNT_W'(PULSE_CYCLES - 1);
        st_nxt = ST_PG_PULSE;
      end
      ST_PG_PULSE: if (cnt_done) begin
        ctl_nxt.select_n = 1'b1;
        cnt_nxt = cyc(HOLD_CYC);
        st_nxt = ST_PG_HOLD;
      end
      ST_PG_HOLD: if (cnt_done) begin
        // Data released only after the hold; address kept to the end
        ctl_nxt.supply_hi = 1'b0;
        oe_nxt = 1'b0;
        cnt_nxt = cyc(SETUP_CYC);
        st_nxt = ST_PG_VSETUP;
      end
      ST_PG_VSETUP: if (cnt_done) begin
        ctl_nxt = '{select_n: 1'b0, gate_n: 1'b0, supply_hi: 1'b0};
        cnt_nxt = cyc(VERIFY_CYC + SYNC_CYC);
        st_nxt = ST_PG_VERIFY;
      end
      ST_PG_VERIFY: if (cnt_done) begin
        ctl_nxt = CTL_IDLE;
        rsp_v_nxt = 1'b1;
        err_nxt = mismatch;
        cnt_nxt = cyc(FLOAT_CYC);
        st_nxt = ST_PG_FLOAT;
      end
      ST_RD_FLOAT, ST_PG_FLOAT: if (cnt_done) begin
        st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // Low in the cycle after a take, so one request is one transfer
  assign ready_nxt = is_idle(st_nxt) && !take;

  // ----------------------------------------
  // Sequence registers
  // ----------------------------------------
  // The counter only runs down; each state loads its own span
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
      ready_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      ready_r <= ready_nxt;
    end
  end

  // ----------------------------------------
  // Pin registers
  // ----------------------------------------
  // One request is one address and one byte, held to the next take
  always_ff @(posedge clk) begin
    if (reset) begin
      ctl_r <= CTL_IDLE;
      oe_r <= 1'b0;
      word_r <= '0;
    end else begin
      ctl_r <= ctl_nxt;
      oe_r <= oe_nxt;
      if (take) word_r <= req_word;
    end
  end

  // ----------------------------------------
  // Answer registers
  // ----------------------------------------
  // Data and error stand until the next answer
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_v_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= ERASED;
    end else begin
      rsp_v_r <= rsp_v_nxt;
      err_r <= err_nxt;
      if (sample) rdata_r <= bl_s2_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every pin comes straight from a flop, so no glitch reaches the part
  assign req_ready = ready_r;
  assign rsp_valid = rsp_v_r;
  assign rsp_data = rdata_r;
  assign rsp_error = err_r;
  assign word_select_lines = word_r.addr;
  assign select_program_strobe_n = ctl_r.select_n;
  assign output_gate_n = ctl_r.gate_n;
  assign supply_high = ctl_r.supply_hi;
  assign byte_lines_out = word_r.data;
  assign byte_lines_oe = oe_r;
endmodule
`default_nettype wire

/* File: design/uvep_pkg.sv */
// Package for the EPROM host controller: pin bundles, modes, timing counts
package uvep_pkg;
  localparam int CLK_NS = 50;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  // Times in their own units
  localparam int ACCESS_NS = 350;
  localparam int GATE_OUT_NS = 150;
  localparam int FLOAT_NS = 130;
  localparam int SETUP_US = 2;
  localparam int HOLD_US = 2;
  localparam int VERIFY_US = 1;
  localparam int PULSE_MS = 50;
  localparam int RISE_NS = 50;
  // Cycle counts: minimums round up
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int GATE_CYC = (GATE_OUT_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLOAT_CYC = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = (SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int VERIFY_CYC = (VERIFY_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int RISE_CYC = (RISE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = PULSE_MS * 1000000 / CLK_NS;
  localparam int CNT_W = 21;
  // Two flops on the byte lines add this much to every sample point
  localparam int SYNC_CYC = 2;
  localparam logic [DATA_W-1:0] ERASED = 8'hff;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } uvep_word_t;

  typedef struct packed {
    logic select_n;
    logic gate_n;
    logic supply_hi;
  } uvep_ctl_t;

  // Standby on the pins: nothing selected, supply at logic level
  localparam uvep_ctl_t CTL_IDLE = '{select_n: 1'b1, gate_n: 1'b1,
    supply_hi: 1'b0};

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RD_ADDR = 4'h1,
    ST_RD_GATE = 4'h2,
    ST_RD_FLOAT = 4'h3,
    ST_PG_SETUP = 4'h4,
    ST_PG_RISE = 4'h5,
    ST_PG_PULSE = 4'h6,
    ST_PG_HOLD = 4'h7,
    ST_PG_VSETUP = 4'h8,
    ST_PG_VERIFY = 4'h9,
    ST_PG_FLOAT = 4'ha
  } uvep_state_t;
endpackage

/* File: verification/uvep_host_properties.sv */
// Pin timing checker bound to the EPROM host controller
`timescale 1ns/10ps
`default_nettype none
module uvep_host_chk
  import uvep_pkg::*;
#(parameter int PULSE_CYCLES = PULSE_CYC) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // User side
  input wire logic req_valid,
  input wire logic req_prog,
  input wire uvep_word_t req_word,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [DATA_W-1:0] rsp_data,
  input wire logic rsp_error,
  // Pins
  input wire logic [ADDR_W-1:0] word_select_lines,
  input wire logic select_program_strobe_n,
  input wire logic output_gate_n,
  input wire logic supply_high,
  input wire logic [DATA_W-1:0] byte_lines_out,
  input wire logic byte_lines_oe,
  input wire logic [DATA_W-1:0] byte_lines_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  localparam int RISE_GAP = RISE_CYC + SETUP_CYC;
  logic [CNT_W-1:0] low_cnt_r;
  wire pulse_on = !select_program_strobe_n && supply_high;
  always_ff @(posedge clk) begin
    low_cnt_r <= pulse_on ? low_cnt_r + CNT_W'(1) : '0;
  end
  sequence s_rise;
    select_program_strobe_n ##RISE_GAP $fell(select_program_strobe_n);
  endsequence
  sequence s_read;
    !select_program_strobe_n ##9 !output_gate_n ##5 rsp_valid;
  endsequence
  idle_pins_a: assert property (req_ready |-> select_program_strobe_n
    && output_gate_n && !supply_high && !byte_lines_oe)
    else $error("pins not idle while ready");
  no_fight_a: assert property (byte_lines_oe |-> output_gate_n)
    else $error("host drives bytes with gate low");
  supply_gate_a: assert property (supply_high |-> output_gate_n
    && byte_lines_oe) else $error("supply high without data");
  rise_time_a: assert property ($rose(supply_high) |-> s_rise)
    else $error("strobe fall not after supply rise");
  pulse_len_a: assert property ($rose(select_program_strobe_n)
    && supply_high |-> low_cnt_r == CNT_W'(PULSE_CYCLES))
    else $error("program pulse length wrong");
  hold_stable_a: assert property (pulse_on |=>
    $stable(word_select_lines) && $stable(byte_lines_out))
    else $error("address or data moved in pulse");
  read_time_a: assert property (req_valid && req_ready
    && !req_prog |-> ##1 s_read) else $error("read timing wrong");
  gate_fall_a: assert property ($fell(output_gate_n) |->
    !select_program_strobe_n && !supply_high)
    else $error("gate low without select");
  float_wait_a: assert property (rsp_valid |=>
    !rsp_valid && !req_ready ##1 !req_ready ##1 req_ready)
    else $error("float gap wrong");
endmodule
bind uvep_host uvep_host_chk #(.PULSE_CYCLES(PULSE_CYCLES)) i_chk (
  .clk(clk), .reset(reset), .req_valid(req_valid), .req_prog(req_prog),
  .req_word(req_word), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .rsp_error(rsp_error),
  .word_select_lines(word_select_lines),
  .select_program_strobe_n(select_program_strobe_n),
  .output_gate_n(output_gate_n), .supply_high(supply_high),
  .byte_lines_out(byte_lines_out), .byte_lines_oe(byte_lines_oe),
  .byte_lines_in(byte_lines_in));
`default_nettype wire

/* File: verification/uvep_prom_model.sv */
// Behavioural EPROM on the far side of the host pins
`timescale 1ns/10ps
`default_nettype none
module uvep_prom_model
  import uvep_pkg::*;
(
  // Clock
  input wire logic clk,
  // Pins from the host
  input wire logic [ADDR_W-1:0] word_select_lines,
  input wire logic select_program_strobe_n,
  input wire logic output_gate_n,
  input wire logic supply_high,
  input wire logic [DATA_W-1:0] byte_lines_out,
  input wire logic byte_lines_oe,
  // Resolved byte lines
  output logic [DATA_W-1:0] byte_lines_in
);
  logic [DATA_W-1:0] mem_r [2**ADDR_W];
  logic [DATA_W-1:0] dev_r;
  wire drive = !select_program_strobe_n && !output_gate_n;
  wire burn = !select_program_strobe_n && supply_high;
  assign byte_lines_in = byte_lines_oe ? byte_lines_out : dev_r;
  initial begin
    foreach (mem_r[i]) mem_r[i] = ERASED;
    dev_r = 8'h00;
  end
  // Floating bus toggles so a stale byte never passes
  always @(posedge clk) begin
    dev_r <= drive ? mem_r[word_select_lines] : ~dev_r;
    if (burn)
      mem_r[word_select_lines] <= mem_r[word_select_lines] & byte_lines_out;
  end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the EPROM host controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin n_compared++; if ((e) !== (a)) begin \
  err_total++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb
  import uvep_pkg::*;
;
  localparam int PCYC = 50;
  localparam int RLAT = 5 + ACCESS_CYC + GATE_CYC;
  localparam int PLAT = 184 + PCYC;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic req_prog = 1'b0;
  uvep_word_t req_word = '0;
  logic req_ready, rsp_valid, rsp_error, sel_n, gate_n, sup, oe;
  logic [DATA_W-1:0] rsp_data, bl_out, bl_in;
  logic [ADDR_W-1:0] wsl;
  int err_total = 0;
  int n_compared = 0;
  int lat;
  always #25 clk = ~clk;
  uvep_host #(.PULSE_CYCLES(PCYC)) i_uvep_host (.clk(clk), .reset(reset),
    .req_valid(req_valid), .req_prog(req_prog), .req_word(req_word),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_error(rsp_error), .word_select_lines(wsl),
    .select_program_strobe_n(sel_n), .output_gate_n(gate_n),
    .supply_high(sup), .byte_lines_out(bl_out), .byte_lines_oe(oe),
    .byte_lines_in(bl_in));
  uvep_prom_model i_uvep_prom_model (.clk(clk), .word_select_lines(wsl),
    .select_program_strobe_n(sel_n), .output_gate_n(gate_n),
    .supply_high(sup), .byte_lines_out(bl_out), .byte_lines_oe(oe),
    .byte_lines_in(bl_in));
  task automatic xfer(input logic p, input logic [11:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (n >= 500) begin
      err_total++;
      $display("[ERR] req_ready exp 1 got %b", req_ready);
    end
    @(posedge clk);
    req_valid <= 1'b1;
    req_prog <= p;
    req_word <= '{addr: a, data: d};
    @(posedge clk);
    req_valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (rsp_valid !== 1'b1 && lat < 1000);
  endtask
  task automatic t_read_erased();
    xfer(1'b0, 12'hfff, 8'h00);
    `CHK("read latency", RLAT, lat)
    `CHK("erased byte", 8'hff, rsp_data)
    `CHK("read error", 1'b0, rsp_error)
    $display("test read_erased done");
  endtask
  task automatic t_program();
    xfer(1'b1, 12'h123, 8'ha5);
    `CHK("program latency", PLAT, lat)
    `CHK("verify byte", 8'ha5, rsp_data)
    `CHK("verify error", 1'b0, rsp_error)
    xfer(1'b0, 12'h123, 8'h00);
    `CHK("readback", 8'ha5, rsp_data)
    $display("test program done");
  endtask
  task automatic t_no_set();
    xfer(1'b1, 12'h123, 8'hff);
    `CHK("no set byte", 8'ha5, rsp_data)
    `CHK("no set error", 1'b1, rsp_error)
    xfer(1'b1, 12'h123, 8'h0f);
    `CHK("and byte", 8'h05, rsp_data)
    `CHK("and error", 1'b1, rsp_error)
    $display("test no_set done");
  endtask
  task automatic t_other();
    xfer(1'b0, 12'h124, 8'h00);
    `CHK("neighbour", 8'hff, rsp_data)
    xfer(1'b0, 12'h000, 8'h00);
    `CHK("low address", 8'hff, rsp_data)
    $display("test other done");
  endtask
  task automatic t_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    `CHK("reset ready", 1'b0, req_ready)
    `CHK("reset select", 1'b1, sel_n)
    `CHK("reset data", ERASED, rsp_data)
    xfer(1'b0, 12'h123, 8'h00);
    `CHK("read after reset", 8'h05, rsp_data)
    $display("test reset done");
  endtask
  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_read_erased();
    t_program();
    t_no_set();
    t_other();
    t_reset();
    print_verdict();
  end
  // Run needs about 820 cycles
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
